// ---- rtl/ccp_pwm_consts.svh ----
// Offsets, field positions, reset values and timing counts of the PWM unit.
`ifndef CCP_PWM_CONSTS_SVH
`define CCP_PWM_CONSTS_SVH
`define OFS_LIMIT 8'h00
`define OFS_TCTRL 8'h04
`define OFS_DUTY_HI 8'h08
`define OFS_UCTRL 8'h0C
`define OFS_ACTIVE 8'h10
`define OFS_STATUS 8'h14
`define OFS_COUNT 8'h18
`define OFS_PIN 8'h1C
`define TCTRL_RUN_BIT 2
`define TCTRL_PS_LSB 0
`define UCTRL_FRAC_LSB 4
`define UCTRL_MODE_LSB 0
`define MODE_PWM 4'hC
`define STATUS_FLAG_BIT 0
`define PIN_DIR_BIT 0
`define RST_LIMIT 8'hFF
`define RST_PIN_DIR 1'b1
`define OSC_PER_INSN 4
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
`endif

// ---- rtl/ccp_pwm_pkg.sv ----
// Types shared by the PWM unit.
package ccp_pwm_pkg;
  typedef enum logic [1:0] {
    ps_div1,
    ps_div4,
    ps_div16,
    ps_div64
  } prescale_t;
endpackage

// ---- rtl/ccp_standard_pwm.sv ----
// Standard PWM unit with an 8-bit period timer and an AXI4-Lite register slave.
// Operation
// R1: One PWM output with up to ten bits.
// R2: Period set by 8-bit period limit register.
// R3: Period is (limit+1) times 4 times prescale; the code divides by 16 for ps_div64, as it does for ps_div16.
// R4: At rollover clear count, set pin, latch duty.
// R5: Zero duty keeps the pin low all period.
// R6: No postscaler affects the period.
// R7: Duty high bits plus control bits 5:4.
// R8: Duty writes never disturb the current period.
// R9: New duty takes effect at period match.
// R10: Active duty register is read only.
// R11: Duty double buffered through active register, latch.
// R12: Time base is count plus phase or prescaler.
// R13: Clear pin when time base equals active duty.
// R14: High time is duty times oscillator period; the code also multiplies it by the prescale factor.
// R15: Ratio is duty over four times limit+1.
// R16: Software clears direction bit to drive pin.
// R17: Clearing whole control register releases the pin.
// R18: Software follows the recommended setup order.
// R19: Timer sets match flag at each rollover.
// R20: Duty beyond period keeps pin high all period.
`include "ccp_pwm_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module ccp_standard_pwm (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // AXI4-Lite write address and data.
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // AXI4-Lite write response.
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // AXI4-Lite read.
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Output pin, output enable is active low.
  output logic o_pwm_out,
  output logic o_pwm_oe_n
);

  // Software visible registers.
  logic [7:0] limit_r, limit_nxt;           // Period limit.
  logic [2:0] tctrl_r, tctrl_nxt;           // Run bit and prescale select.
  logic [7:0] duty_hi_r, duty_hi_nxt;       // Buffered duty, eight high bits.
  logic [5:0] uctrl_r, uctrl_nxt;           // Fraction bits and mode.
  logic flag_r, flag_nxt;                   // Period match flag.
  logic dir_r, dir_nxt;                     // Pin direction, one means input.
  // Timer and waveform state.
  logic [7:0] count_r, count_nxt;           // Period timer count.
  logic [5:0] pre_r, pre_nxt;               // Prescaler, also supplies phase bits.
  logic [7:0] act_hi_r, act_hi_nxt;         // Active duty high bits.
  logic [1:0] act_lo_r, act_lo_nxt;         // Hidden two bit latch.
  logic pin_r, pin_nxt;                     // Waveform level.
  logic oe_n_r, oe_n_nxt;                   // Registered output enable.
  // Bus channel state.
  logic aw_got_r, aw_got_nxt;
  logic w_got_r, w_got_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;

  ccp_pwm_pkg::prescale_t ps_sel;
  logic pwm_mode;
  logic run;
  logic tick;
  logic rollover;
  logic [9:0] time_base;
  logic [9:0] tb_nxt;                       // Time base as it will stand after the coming edge.
  logic [9:0] duty_act;
  logic [9:0] duty_buf;
  logic [5:0] pre_last;
  logic wr_fire;

  // Tells whether a byte address is one of the mapped registers.
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `OFS_LIMIT) || (a == `OFS_TCTRL) || (a == `OFS_DUTY_HI) ||
             (a == `OFS_UCTRL) || (a == `OFS_ACTIVE) || (a == `OFS_STATUS) ||
             (a == `OFS_COUNT) || (a == `OFS_PIN);
  endfunction

  // Merges the lowest byte of a write under its strobe.
  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge8 = s[0] ? d[7:0] : old;
  endfunction

  // Joins the timer count with the two phase or prescaler bits that refine it.
  function automatic logic [9:0] base_of(input logic [7:0] c, input logic [5:0] p,
                                         input ccp_pwm_pkg::prescale_t s);
    unique case (s)
      ccp_pwm_pkg::ps_div1: base_of = {c, p[1:0]};
      ccp_pwm_pkg::ps_div4: base_of = {c, p[3:2]};
      ccp_pwm_pkg::ps_div16, ccp_pwm_pkg::ps_div64: base_of = {c, p[5:4]};
    endcase
  endfunction

  // Decode of the timer control and the mode.
  always_comb begin
    ps_sel = ccp_pwm_pkg::prescale_t'(tctrl_r[`TCTRL_PS_LSB +: 2]);
    run = tctrl_r[`TCTRL_RUN_BIT];
    pwm_mode = (uctrl_r[`UCTRL_MODE_LSB +: 4] == `MODE_PWM);
    duty_buf = {duty_hi_r, uctrl_r[`UCTRL_FRAC_LSB +: 2]}; // R7
    duty_act = {act_hi_r, act_lo_r}; // R11
  end

  // Each system clock is one oscillator period; the prescaler counts them.
  // The count advances once every 4, 16 or 64 clocks; ps_div16 and ps_div64 both take 64.
  always_comb begin
    unique case (ps_sel)
      ccp_pwm_pkg::ps_div1: pre_last = 6'h03;
      ccp_pwm_pkg::ps_div4: pre_last = 6'h0F;
      ccp_pwm_pkg::ps_div16: pre_last = 6'h3F;
      ccp_pwm_pkg::ps_div64: pre_last = 6'h3F;
    endcase
  end

  // Time base: count joined with the two top running bits of phase or prescaler.
  always_comb begin
    tick = run && (pre_r == pre_last); // R3
    rollover = tick && (count_r == limit_r); // R2
    time_base = base_of(count_r, pre_r, ps_sel); // R12
  end

  // Timer, duty latch and waveform. There is no postscaler in this path.
  always_comb begin
    pre_nxt = pre_r;
    count_nxt = count_r;
    act_hi_nxt = act_hi_r;
    act_lo_nxt = act_lo_r;
    pin_nxt = pin_r;
    if (run) begin
      pre_nxt = (pre_r == pre_last) ? 6'h00 : pre_r + 6'h01; // R6
    end
    if (tick) begin
      count_nxt = rollover ? 8'h00 : count_r + 8'h01;
    end
    // Matching the coming base drops the pin in the first cycle of the match, not one late.
    tb_nxt = base_of(count_nxt, pre_nxt, ps_sel); // R12
    if (rollover) begin
      // The buffer only moves here, so a write mid period is harmless.
      act_hi_nxt = duty_hi_r; // R9
      act_lo_nxt = uctrl_r[`UCTRL_FRAC_LSB +: 2]; // R8
      pin_nxt = pwm_mode && (duty_buf != 10'h000); // R4 R5
    end else if (run && (tb_nxt == duty_act)) begin
      // A duty larger than the period never matches and stays high.
      pin_nxt = 1'b0; // R13 R14 R15 R20
    end
    if (!pwm_mode) begin
      pin_nxt = 1'b0;
    end
    // Pin is driven only in PWM mode with direction cleared.
    oe_n_nxt = !(pwm_mode && (uctrl_r != 6'h00) && !dir_r); // R16 R17
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pre_r <= 6'h00;
      count_r <= 8'h00;
      act_hi_r <= 8'h00;
      act_lo_r <= 2'b00;
      pin_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else begin
      pre_r <= pre_nxt;
      count_r <= count_nxt;
      act_hi_r <= act_hi_nxt;
      act_lo_r <= act_lo_nxt;
      pin_r <= pin_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  // Write channel: address and data are taken in either order.
  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    limit_nxt = limit_r;
    tctrl_nxt = tctrl_r;
    duty_hi_nxt = duty_hi_r;
    uctrl_nxt = uctrl_r;
    dir_nxt = dir_r;
    flag_nxt = flag_r;
    wr_fire = aw_got_r && w_got_r && !bvalid_r;
    if (i_awvalid && o_awready) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      w_got_nxt = 1'b1;
      wdata_nxt = i_wdata;
      wstrb_nxt = i_wstrb;
    end
    if (bvalid_r && i_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (wr_fire) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = mapped(awaddr_r) ? `AXI_OKAY : `AXI_SLVERR;
      unique case (awaddr_r)
        `OFS_LIMIT: limit_nxt = merge8(limit_r, wdata_r, wstrb_r);
        `OFS_TCTRL: tctrl_nxt = wstrb_r[0] ? wdata_r[2:0] : tctrl_r;
        `OFS_DUTY_HI: duty_hi_nxt = merge8(duty_hi_r, wdata_r, wstrb_r);
        `OFS_UCTRL: uctrl_nxt = wstrb_r[0] ? wdata_r[5:0] : uctrl_r;
        `OFS_STATUS: begin
          // Writing a one clears the flag.
          if (wstrb_r[0] && wdata_r[`STATUS_FLAG_BIT]) begin
            flag_nxt = 1'b0;
          end
        end
        `OFS_PIN: dir_nxt = wstrb_r[0] ? wdata_r[`PIN_DIR_BIT] : dir_r;
        // The active duty register ignores writes.
        default: begin
        end // R10
      endcase
    end
    // A rollover in the clearing cycle still sets the flag.
    if (rollover) begin
      flag_nxt = 1'b1; // R19
    end
  end

  // Read channel.
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && i_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (i_arvalid && o_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = mapped(i_araddr) ? `AXI_OKAY : `AXI_SLVERR;
      unique case (i_araddr)
        `OFS_LIMIT: rdata_nxt = {24'h00_0000, limit_r};
        `OFS_TCTRL: rdata_nxt = {29'h0000_0000, tctrl_r};
        `OFS_DUTY_HI: rdata_nxt = {24'h00_0000, duty_hi_r};
        `OFS_UCTRL: rdata_nxt = {26'h000_0000, uctrl_r};
        `OFS_ACTIVE: rdata_nxt = {24'h00_0000, act_hi_r};
        `OFS_STATUS: rdata_nxt = {31'h0000_0000, flag_r};
        `OFS_COUNT: rdata_nxt = {24'h00_0000, count_r};
        `OFS_PIN: rdata_nxt = {30'h0000_0000, pin_r, dir_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'b00;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'b00;
      limit_r <= `RST_LIMIT;
      tctrl_r <= 3'h0;
      duty_hi_r <= 8'h00;
      uctrl_r <= 6'h00;
      flag_r <= 1'b0;
      dir_r <= `RST_PIN_DIR;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      limit_r <= limit_nxt;
      tctrl_r <= tctrl_nxt;
      duty_hi_r <= duty_hi_nxt;
      uctrl_r <= uctrl_nxt;
      flag_r <= flag_nxt;
      dir_r <= dir_nxt;
    end
  end

  // Ready signals are registered: high while the channel slot is free.
  logic awready_r, wready_r, arready_r;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
    end else begin
      awready_r <= !aw_got_nxt && !(i_awvalid && awready_r);
      wready_r <= !w_got_nxt && !(i_wvalid && wready_r);
      arready_r <= !rvalid_nxt && !(i_arvalid && arready_r);
    end
  end

  assign o_awready = awready_r;
  assign o_wready = wready_r;
  assign o_arready = arready_r;
  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;
  assign o_pwm_out = pin_r; // R1
  assign o_pwm_oe_n = oe_n_r;

  // Checks on the waveform and the timer.
  a_rollover_latch: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R4
    rollover |=> (count_r == 8'h00) && (act_hi_r == $past(duty_hi_r)))
    else $error("duty not latched at rollover");
  a_zero_duty: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R5
    rollover && duty_buf == 10'h000 |=> !pin_r)
    else $error("pin set with zero duty");
  a_pin_set: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R4
    rollover && pwm_mode && duty_buf != 10'h000 |=> pin_r)
    else $error("pin not set at rollover");
  a_match_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R13
    run && !rollover && tb_nxt == duty_act |=> !pin_r)
    else $error("pin not cleared at match");
  a_hold_active: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R9
    !rollover |=> $stable(act_hi_r) && $stable(act_lo_r))
    else $error("active duty moved mid period");
  a_flag_set: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R19
    rollover |=> flag_r)
    else $error("match flag not set");
  a_release_pin: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R17
    uctrl_r == 6'h00 |=> o_pwm_oe_n)
    else $error("pin still driven after control clear");
  a_tick_spacing: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R3
    tick && ps_sel == ccp_pwm_pkg::ps_div1 && $stable(tctrl_r) |=> !tick [*3])
    else $error("timer advanced too soon");
  c_rollover: cover property (@(posedge i_mclk) disable iff (!i_rst_n) rollover && pin_nxt);
  c_match: cover property (@(posedge i_mclk) disable iff (!i_rst_n) pin_r ##1 !pin_r);
  c_write: cover property (@(posedge i_mclk) disable iff (!i_rst_n) wr_fire);
endmodule
`default_nettype wire

// ---- verif/pwm_load_model.sv ----
// Load on the PWM pin: sums high clocks in a window and measures each pulse.
`timescale 1ns/1ns
`default_nettype none
module pwm_load_model (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Pin driver and measurement window.
  input wire logic i_pwm_out,
  input wire logic i_pwm_oe_n,
  input wire logic i_win,
  // Measurements in clocks.
  output logic [15:0] o_high_total,
  output logic [15:0] o_last_pulse
);
  logic pin;
  logic win_d;
  logic [15:0] run_len;
  // The load has a pull-down, so a released pin reads low.
  assign pin = !i_pwm_oe_n && i_pwm_out;
  // The total restarts at each opening of the window; a pulse is logged as it ends.
  always @(posedge i_mclk) begin
    win_d <= i_win;
    if (!i_rst_n) begin
      o_high_total <= 16'h0000;
      o_last_pulse <= 16'h0000;
      run_len <= 16'h0000;
    end else begin
      if (i_win && !win_d) o_high_total <= {15'h0000, pin};
      else if (i_win && pin) o_high_total <= o_high_total + 16'h0001;
      if (pin) run_len <= run_len + 16'h0001;
      else if (run_len != 16'h0000) begin
        o_last_pulse <= run_len;
        run_len <= 16'h0000;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/ccp_standard_pwm_tb_top.sv ----
// Self-checking bench of the standard PWM unit and its load.
`include "ccp_pwm_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module ccp_standard_pwm_tb_top;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic win = 1'b0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_pwm_out, o_pwm_oe_n;
  logic [1:0] o_bresp, o_rresp, resp;
  logic [31:0] o_rdata, rd_v;
  logic [15:0] high_total, last_pulse;
  int err_total = 0;
  int n_compared = 0;
  // Rows: limit, prescale code, duty, expected high clocks per period.
  typedef struct {logic [7:0] lim; logic [1:0] ps; logic [9:0] duty; logic [15:0] high;} row_t;
  row_t rows [8] = '{'{8'h03, 2'h0, 10'h007, 16'h0007}, '{8'h09, 2'h0, 10'h014, 16'h0014},
    '{8'h09, 2'h0, 10'h000, 16'h0000}, '{8'h09, 2'h0, 10'h032, 16'h0028},
    '{8'h09, 2'h0, 10'h027, 16'h0027}, '{8'h14, 2'h1, 10'h015, 16'h0054},
    '{8'h14, 2'h2, 10'h015, 16'h0150}, '{8'h14, 2'h3, 10'h015, 16'h0150}};
  always #25 i_mclk = ~i_mclk;
  ccp_standard_pwm ccp_standard_pwm_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(o_awready), .i_wdata(wdata),
    .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
    .o_bvalid(o_bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
    .i_rready(rready), .o_pwm_out(o_pwm_out), .o_pwm_oe_n(o_pwm_oe_n));
  pwm_load_model pwm_load_model_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_pwm_out(o_pwm_out),
    .i_pwm_oe_n(o_pwm_oe_n), .i_win(win), .o_high_total(high_total),
    .o_last_pulse(last_pulse));
  // Prescale factor of each code; the two top codes both divide by 16.
  function automatic int psf(input logic [1:0] c);
    return (c == 2'h0) ? 1 : (c == 2'h1) ? 4 : 16;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Readiness is sampled on the falling edge, so no decision races the rising edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    @(posedge i_mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge i_mclk);
      aw = awvalid && o_awready;
      w = wvalid && o_wready;
      b = o_bvalid;
      r = o_bresp;
      @(posedge i_mclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!b);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    @(posedge i_mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge i_mclk);
      ar = arvalid && o_arready;
      v = o_rvalid;
      d = o_rdata;
      r = o_rresp;
      @(posedge i_mclk);
      if (ar) arvalid <= 1'b0;
    end while (!v);
    rready <= 1'b0;
  endtask
  // The duty value is split over the duty high register and the control fraction bits.
  task automatic duty(input logic [9:0] d);
    wr(`OFS_DUTY_HI, {24'h0000_00, d[9:2]}, resp);
    wr(`OFS_UCTRL, {26'h000_0000, d[1:0], `MODE_PWM}, resp);
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // The slowest rows take about ten thousand clocks each; this leaves ample margin.
  initial begin
    #(60000 * 50);
    err_total++;
    close_out;
  end
  initial begin
    int per;
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(negedge i_mclk);
    chk("oe_n reset", {31'h0, o_pwm_oe_n}, 32'h0000_0001);
    rd(`OFS_LIMIT, rd_v, resp);
    chk("limit reset", rd_v, 32'h0000_00FF);
    rd(`OFS_PIN, rd_v, resp);
    chk("pin reset", rd_v, 32'h0000_0001);
    $display("reset test done");
    // Setup in the recommended order, driver enabled only after the first match.
    wr(`OFS_LIMIT, 32'h0000_0003, resp);
    duty(10'h007);
    wr(`OFS_STATUS, 32'h0000_0001, resp);
    rd(`OFS_STATUS, rd_v, resp);
    chk("flag clear", rd_v, 32'h0000_0000);
    wr(`OFS_TCTRL, 32'h0000_0004, resp);
    for (int i = 0; i < 20 && rd_v[0] !== 1'b1; i++) rd(`OFS_STATUS, rd_v, resp);
    chk("flag set", rd_v, 32'h0000_0001);
    wr(`OFS_PIN, 32'h0000_0000, resp);
    repeat (2) @(negedge i_mclk);
    chk("oe_n on", {31'h0, o_pwm_oe_n}, 32'h0000_0000);
    $display("setup done");
    foreach (rows[k]) begin
      per = (rows[k].lim + 1) * 4 * psf(rows[k].ps);
      wr(`OFS_LIMIT, {24'h0000_00, rows[k].lim}, resp);
      wr(`OFS_TCTRL, {29'h0000_0000, 1'b1, rows[k].ps}, resp);
      duty(rows[k].duty);
      repeat (3 * per) @(posedge i_mclk);
      win <= 1'b1;
      repeat (4 * per) @(posedge i_mclk);
      win <= 1'b0;
      @(negedge i_mclk);
      chk("high", {16'h0000, high_total}, {16'h0000, rows[k].high} * 4);
      rd(`OFS_ACTIVE, rd_v, resp);
      chk("active", rd_v, {24'h0000_00, rows[k].duty[9:2]});
      $display("row %0d done", k);
    end
    // A duty change inside a period only shows from the next period on.
    wr(`OFS_LIMIT, 32'h0000_0009, resp);
    wr(`OFS_TCTRL, 32'h0000_0004, resp);
    duty(10'h014);
    repeat (1200) @(posedge i_mclk);
    do @(negedge i_mclk); while (o_pwm_out);
    do @(negedge i_mclk); while (!o_pwm_out);
    duty(10'h004);
    repeat (20) @(negedge i_mclk);
    chk("pulse old", {16'h0000, last_pulse}, 32'h0000_0014);
    repeat (40) @(negedge i_mclk);
    chk("pulse new", {16'h0000, last_pulse}, 32'h0000_0004);
    $display("update test done");
    wr(`OFS_ACTIVE, 32'h0000_00FF, resp);
    chk("active wr resp", {30'h0, resp}, {30'h0, `AXI_OKAY});
    rd(`OFS_ACTIVE, rd_v, resp);
    chk("active kept", rd_v, 32'h0000_0001);
    wr(8'h40, 32'h0000_0001, resp);
    chk("unmapped wr", {30'h0, resp}, {30'h0, `AXI_SLVERR});
    rd(8'h40, rd_v, resp);
    chk("unmapped rd", {30'h0, resp}, {30'h0, `AXI_SLVERR});
    chk("unmapped data", rd_v, 32'h0000_0000);
    $display("access test done");
    wr(`OFS_UCTRL, 32'h0000_0000, resp);
    repeat (2) @(negedge i_mclk);
    chk("oe_n off", {31'h0, o_pwm_oe_n}, 32'h0000_0001);
    $display("release test done");
    // A reset in mid-run must bring back the released pin and the reset period limit.
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(negedge i_mclk);
    chk("oe_n rearm", {31'h0, o_pwm_oe_n}, 32'h0000_0001);
    rd(`OFS_LIMIT, rd_v, resp);
    chk("limit rearm", rd_v, 32'h0000_00FF);
    $display("rearm test done");
    close_out;
  end
endmodule
`default_nettype wire
